/* logic/dbc_pkg.sv */
// Constants for the DMA byte counter block.
// Assumes a 25 MHz controller clock and a byte-wide register port.
package dbc_pkg;
    // ========================================
    // Register map
    localparam logic [7:0]  CMD_OFFSET       = 8'h30;
    localparam logic [7:0]  COUNT_OFFSET_B0  = 8'h34;
    localparam logic [7:0]  COUNT_OFFSET_B1  = 8'h35;
    localparam logic [7:0]  COUNT_OFFSET_B2  = 8'h36;
    localparam logic [7:0]  COUNT_OFFSET_B3  = 8'h37;
    localparam logic [31:0] COUNT_RESET      = 32'h00000000;
    localparam logic [7:0]  CMD_READ_VALUE   = 8'hff;
    localparam logic [7:0]  UNMAPPED_VALUE   = 8'h00;
    // ========================================
    // Commands
    localparam logic [7:0]  BUS_TO_BUFFER_TRANSFER_CMD = 8'h00;
    localparam logic [7:0]  BUFFER_TO_BUS_TRANSFER_CMD = 8'h01;
    localparam logic [7:0]  STOP_TRANSFER_CMD          = 8'h13;
    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int FIFO_DELAY_NS   = 60;
    // Longest time, rounded down, at least one cycle
    localparam int FIFO_DELAY_CYC  =
        (FIFO_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (FIFO_DELAY_NS / CLK_PERIOD_NS);
    localparam int FIFO_DEPTH      = 8;
    typedef enum logic [2:0] {
        DBC_IDLE = 3'b001,
        DBC_IN   = 3'b010,
        DBC_OUT  = 3'b100
    } dbc_state_t;
endpackage

/* logic/dbc_counter.sv */
// DMA byte counter with its byte FIFO between DMA bus and endpoint buffer.
// Assumes DMA bus strobes come from logic on i_clk, and the endpoint
// buffer accepts a byte whenever o_buf_wr_valid is high on IN transfers.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: Software loads a 32-bit byte total first; device holds it.
// RULE_02: Reading the counter during a transfer returns bytes not yet moved.
// RULE_03: IN transfers pass through a FIFO of at most eight bytes.
// RULE_04: IN bytes reach the endpoint buffer within 60 ns of entering FIFO.
// RULE_05: OUT buffer contents stay valid until the FIFO is fully drained.
// RULE_06: Counter keeps decrementing and wraps past zero, never saturates.
// RULE_07: Counter sits at 0x34 as four bytes, top byte holds bits 31:24.
// RULE_08: Command 0x00 moves bus to buffer, 0x01 buffer to bus.
// RULE_09: Counter drops by one in the cycle each DMA byte completes.
module dbc_counter #(
    parameter int DEPTH = dbc_pkg::FIFO_DEPTH
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_usb_bus_reset,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic [7:0] i_dma_wdata,
    input  wire logic       i_dma_wr,
    output logic      [7:0] o_dma_rdata,
    input  wire logic       i_dma_rd,
    output logic            o_dma_rd_valid,
    output logic            o_dma_wr_ready,
    output logic      [7:0] o_buf_wr_data,
    output logic            o_buf_wr_valid,
    input  wire logic [7:0] i_buf_rd_data,
    input  wire logic       i_buf_rd_avail,
    output logic            o_buf_rd_take,
    output logic            o_buf_hold,
    output logic            o_busy
);
    localparam int AW = $clog2(DEPTH);

    // ========================================
    // Registers and state
    logic [31:0]              count;
    dbc_pkg::dbc_state_t      state;
    logic [7:0]               fifo_mem [DEPTH];
    logic [AW-1:0]            wr_ptr;
    logic [AW-1:0]            rd_ptr;
    logic [AW:0]              fill;
    logic [7:0]               next_rdata;

    wire cmd_wr   = i_wr && i_addr == dbc_pkg::CMD_OFFSET;
    wire in_push  = state == dbc_pkg::DBC_IN && i_dma_wr &&
                    fill < (AW+1)'(DEPTH);
    // IN drain: one byte per cycle toward the endpoint buffer
    wire in_pop   = state == dbc_pkg::DBC_IN && fill != '0;
    wire out_push = state == dbc_pkg::DBC_OUT && i_buf_rd_avail &&
                    fill < (AW+1)'(DEPTH);
    wire out_pop  = state == dbc_pkg::DBC_OUT && i_dma_rd && fill != '0;
    wire push     = in_push || out_push;
    wire pop      = in_pop || out_pop;
    wire dma_byte = in_push || out_pop;

    // ========================================
    // Transfer state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= dbc_pkg::DBC_IDLE;
        end else if (i_clk_en) begin
            if (i_usb_bus_reset) begin
                state <= dbc_pkg::DBC_IDLE;
            end else if (cmd_wr) begin
                case (i_wdata)
                    dbc_pkg::BUS_TO_BUFFER_TRANSFER_CMD: begin
                        state <= dbc_pkg::DBC_IN; // RULE_08
                    end
                    dbc_pkg::BUFFER_TO_BUS_TRANSFER_CMD: begin
                        state <= dbc_pkg::DBC_OUT; // RULE_08
                    end
                    dbc_pkg::STOP_TRANSFER_CMD: begin
                        state <= dbc_pkg::DBC_IDLE;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // ========================================
    // Byte counter
    // Byte-wide writes; a write beats a same-cycle decrement
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= dbc_pkg::COUNT_RESET;
        end else if (i_clk_en) begin
            if (i_usb_bus_reset) begin
                count <= dbc_pkg::COUNT_RESET;
            end else if (i_wr && i_addr == dbc_pkg::COUNT_OFFSET_B0) begin
                count[7:0] <= i_wdata; // RULE_01
            end else if (i_wr && i_addr == dbc_pkg::COUNT_OFFSET_B1) begin
                count[15:8] <= i_wdata; // RULE_01
            end else if (i_wr && i_addr == dbc_pkg::COUNT_OFFSET_B2) begin
                count[23:16] <= i_wdata; // RULE_07
            end else if (i_wr && i_addr == dbc_pkg::COUNT_OFFSET_B3) begin
                count[31:24] <= i_wdata; // RULE_07
            end else if (dma_byte) begin
                // Plain modular subtract, wraps at zero
                count <= count - 32'h00000001; // RULE_06 RULE_09
            end
        end
    end

    // ========================================
    // Byte FIFO
    always_ff @(posedge i_clk) begin
        if (i_clk_en && push) begin
            fifo_mem[wr_ptr] <= in_push ? i_dma_wdata : i_buf_rd_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else if (i_clk_en) begin
            if (i_usb_bus_reset || (cmd_wr && state == dbc_pkg::DBC_IDLE))
            begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                fill   <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= AW'((32'(wr_ptr) + 1) % DEPTH); // RULE_03
                end
                if (pop) begin
                    rd_ptr <= AW'((32'(rd_ptr) + 1) % DEPTH);
                end
                fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end

    // ========================================
    // Outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_buf_wr_data  <= 8'h00;
            o_buf_wr_valid <= 1'b0;
            o_dma_rdata    <= 8'h00;
            o_dma_rd_valid <= 1'b0;
        end else if (i_clk_en) begin
            o_buf_wr_valid <= in_pop; // RULE_04
            o_dma_rd_valid <= out_pop;
            if (pop) begin
                o_buf_wr_data <= fifo_mem[rd_ptr];
                o_dma_rdata   <= fifo_mem[rd_ptr];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dma_wr_ready <= 1'b0;
            o_buf_rd_take  <= 1'b0;
            o_buf_hold     <= 1'b0;
            o_busy         <= 1'b0;
        end else if (i_clk_en) begin
            o_dma_wr_ready <= state == dbc_pkg::DBC_IN &&
                              fill + (AW+1)'(push) < (AW+1)'(DEPTH);
            o_buf_rd_take  <= out_push;
            // Buffer stays uncleared while OUT bytes remain
            o_buf_hold     <= state == dbc_pkg::DBC_OUT ||
                              fill != '0; // RULE_05
            o_busy         <= state != dbc_pkg::DBC_IDLE;
        end
    end

    // ========================================
    // Register read
    always_comb begin
        case (i_addr)
            dbc_pkg::COUNT_OFFSET_B0: next_rdata = count[7:0]; // RULE_02
            dbc_pkg::COUNT_OFFSET_B1: next_rdata = count[15:8];
            dbc_pkg::COUNT_OFFSET_B2: next_rdata = count[23:16];
            dbc_pkg::COUNT_OFFSET_B3: next_rdata = count[31:24];
            dbc_pkg::CMD_OFFSET:      next_rdata = dbc_pkg::CMD_READ_VALUE;
            default:                  next_rdata = dbc_pkg::UNMAPPED_VALUE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_clk_en && i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // ========================================
    // Checks
    count_load_a: assert property (@(posedge i_clk) // RULE_01
        disable iff (!i_reset_n)
        i_clk_en && !i_usb_bus_reset && i_wr &&
        i_addr == dbc_pkg::COUNT_OFFSET_B3
        |=> count[31:24] == $past(i_wdata))
        else $error("top count byte not loaded");
    count_read_a: assert property (@(posedge i_clk) // RULE_02
        disable iff (!i_reset_n)
        i_clk_en && i_rd && i_addr == dbc_pkg::COUNT_OFFSET_B0
        |=> o_rdata == $past(count[7:0]))
        else $error("count read wrong");
    fifo_bound_a: assert property (@(posedge i_clk) // RULE_03
        disable iff (!i_reset_n)
        fill <= (AW+1)'(DEPTH))
        else $error("fifo over depth");
    in_drain_a: assert property (@(posedge i_clk) // RULE_04
        disable iff (!i_reset_n)
        i_clk_en && in_push |=> ##[0:3] o_buf_wr_valid)
        else $error("in byte not drained");
    out_hold_a: assert property (@(posedge i_clk) // RULE_05
        disable iff (!i_reset_n)
        i_clk_en && fill != '0 |=> o_buf_hold)
        else $error("buffer released early");
    count_wrap_a: assert property (@(posedge i_clk) // RULE_06
        disable iff (!i_reset_n)
        i_clk_en && !i_usb_bus_reset && !i_wr && dma_byte &&
        count == 32'h00000000
        |=> count == 32'hffffffff)
        else $error("counter did not wrap");
    cmd_start_a: assert property (@(posedge i_clk) // RULE_08
        disable iff (!i_reset_n)
        i_clk_en && !i_usb_bus_reset && cmd_wr &&
        i_wdata == dbc_pkg::BUFFER_TO_BUS_TRANSFER_CMD
        |=> state == dbc_pkg::DBC_OUT ##1 (o_busy || !i_clk_en))
        else $error("out command not started");
    count_step_a: assert property (@(posedge i_clk) // RULE_09
        disable iff (!i_reset_n)
        i_clk_en && !i_usb_bus_reset && !i_wr && dma_byte
        |=> count == $past(count) - 32'h00000001)
        else $error("count step wrong");

    // ========================================
    // Checks on enable, reset and handshake outputs
    // Low enable must freeze everything, bus reset included
    freeze_state_a: assert property (@(posedge i_clk) // RULE_01
        disable iff (!i_reset_n)
        !i_clk_en |=> $stable(count) && $stable(state) &&
        $stable(fill))
        else $error("state moved while frozen");
    idle_count_a: assert property (@(posedge i_clk) // RULE_01
        disable iff (!i_reset_n)
        i_clk_en && state == dbc_pkg::DBC_IDLE && !i_wr &&
        !i_usb_bus_reset |=> count == $past(count))
        else $error("idle count drifted");
    bus_reset_a: assert property (@(posedge i_clk) // RULE_07
        disable iff (!i_reset_n)
        i_clk_en && i_usb_bus_reset |=> count == dbc_pkg::COUNT_RESET &&
        state == dbc_pkg::DBC_IDLE)
        else $error("bus reset did not clear");
    ready_full_a: assert property (@(posedge i_clk) // RULE_03
        disable iff (!i_reset_n)
        i_clk_en && fill == (AW+1)'(DEPTH) |=> !o_dma_wr_ready)
        else $error("ready while fifo full");
    // A held IN byte must leave on the very next edge
    drain_pace_a: assert property (@(posedge i_clk) // RULE_04
        disable iff (!i_reset_n)
        i_clk_en && state == dbc_pkg::DBC_IN && fill != '0
        |=> o_buf_wr_valid)
        else $error("in byte held too long");
    hold_out_a: assert property (@(posedge i_clk) // RULE_05
        disable iff (!i_reset_n)
        i_clk_en && state == dbc_pkg::DBC_OUT |=> o_buf_hold)
        else $error("buffer released in out");
    take_pulse_a: assert property (@(posedge i_clk) // RULE_05
        disable iff (!i_reset_n)
        i_clk_en |=> o_buf_rd_take == $past(out_push))
        else $error("take pulse wrong");
    rd_valid_a: assert property (@(posedge i_clk) // RULE_09
        disable iff (!i_reset_n)
        i_clk_en |=> o_dma_rd_valid == $past(out_pop))
        else $error("out valid pulse wrong");
    in_start_a: assert property (@(posedge i_clk) // RULE_08
        disable iff (!i_reset_n)
        i_clk_en && !i_usb_bus_reset && cmd_wr &&
        i_wdata == dbc_pkg::BUS_TO_BUFFER_TRANSFER_CMD
        |=> state == dbc_pkg::DBC_IN)
        else $error("in command not started");
    stop_idle_a: assert property (@(posedge i_clk) // RULE_08
        disable iff (!i_reset_n)
        i_clk_en && cmd_wr && i_wdata == dbc_pkg::STOP_TRANSFER_CMD
        |=> state == dbc_pkg::DBC_IDLE)
        else $error("stop did not idle");
    busy_flag_a: assert property (@(posedge i_clk) // RULE_08
        disable iff (!i_reset_n)
        i_clk_en |=> o_busy == ($past(state) != dbc_pkg::DBC_IDLE))
        else $error("busy flag wrong");
endmodule

/* tb/dbc_buf_partner.sv */
// Endpoint buffer stand-in offering OUT bytes one at a time.
// Assumes the counter block sits in an OUT transfer while i_enable is high.
`timescale 1ns/1ns
module dbc_buf_partner (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_enable,
    input  wire logic       i_take,
    output logic            o_avail,
    output logic      [7:0] o_data
);
    logic       pending;
    logic [7:0] next_byte;
    // ========================================
    // Offer, then wait for the take pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avail   <= 1'b0;
            pending   <= 1'b0;
            next_byte <= 8'ha0;
            o_data    <= 8'h5f;
        end else begin
            o_avail <= i_enable && !pending;
            if (i_enable && !pending) begin
                pending <= 1'b1;
                o_data  <= next_byte;
            end else begin
                o_data <= ~o_data; // Byte no longer offered: junk on lines
            end
            if (i_take) begin
                pending   <= 1'b0;
                next_byte <= next_byte + 8'h01;
            end
        end
    end
endmodule

/* tb/dbc_counter_bench.sv */
// Self-checking bench for the DMA byte counter.
// Assumes the buffer partner model and a 25 MHz clock.
`timescale 1ns/1ns
module dbc_counter_bench;
    logic        i_clk = 0, i_reset_n = 0, i_usb_bus_reset = 0, i_clk_en = 1;
    logic        i_wr = 0, i_rd = 0, i_dma_wr = 0, i_dma_rd = 0, out_en = 0;
    logic [7:0]  i_addr = 0, i_wdata = 0, i_dma_wdata = 0, b;
    logic [7:0]  o_rdata, o_dma_rdata, o_buf_wr_data, i_buf_rd_data;
    logic        o_dma_rd_valid, o_dma_wr_ready, o_buf_wr_valid;
    logic        i_buf_rd_avail, o_buf_rd_take, o_buf_hold, o_busy;
    logic [31:0] v, model;
    logic [7:0]  in_q[$];
    int          err_total = 0, checked = 0, takes = 0, t;
    always #20 i_clk = ~i_clk;
    dbc_counter dbc_counter_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en), .i_usb_bus_reset(i_usb_bus_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_dma_wdata(i_dma_wdata), .i_dma_wr(i_dma_wr),
        .o_dma_rdata(o_dma_rdata), .i_dma_rd(i_dma_rd),
        .o_dma_rd_valid(o_dma_rd_valid), .o_dma_wr_ready(o_dma_wr_ready),
        .o_buf_wr_data(o_buf_wr_data), .o_buf_wr_valid(o_buf_wr_valid),
        .i_buf_rd_data(i_buf_rd_data), .i_buf_rd_avail(i_buf_rd_avail),
        .o_buf_rd_take(o_buf_rd_take), .o_buf_hold(o_buf_hold),
        .o_busy(o_busy));
    dbc_buf_partner dbc_buf_partner_inst (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_enable(out_en), .i_take(o_buf_rd_take),
        .o_avail(i_buf_rd_avail), .o_data(i_buf_rd_data));
    // ========================================
    // Shared tasks
    task automatic stop_test();
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic wr_count(input logic [31:0] c);
        for (int k = 0; k < 4; k++) wr(8'h34 + 8'(k), c[8*k +: 8]);
    endtask
    task automatic rd_count(output logic [31:0] c);
        logic [7:0] x;
        for (int k = 0; k < 4; k++) begin
            rd(dbc_pkg::COUNT_OFFSET_B0 + 8'(k), x);
            c[8*k +: 8] = x;
        end
    endtask
    task automatic timeout(input int n);
        if (n >= 50) begin
            err_total++;
            $display("[FAIL] handshake expected 1 seen timeout");
            stop_test();
        end
    endtask
    // ========================================
    // Buffer side monitor, pulses stand one cycle
    always @(posedge i_clk) begin
        if (o_buf_wr_valid === 1'b1) begin
            b = (in_q.size() > 0) ? in_q.pop_front() : 8'hxx;
            chk("buf_wr_data", b, o_buf_wr_data);
        end
        if (o_buf_rd_take === 1'b1) takes++;
    end
    initial begin
        void'($urandom(32'h076bcc56));
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_count(v);
        chk("count_reset", dbc_pkg::COUNT_RESET, v);
        model = $urandom;
        wr_count(model);
        rd_count(v);
        chk("count_load", model, v);
        rd(dbc_pkg::CMD_OFFSET, b);
        chk("cmd_read", dbc_pkg::CMD_READ_VALUE, b);
        rd(8'h40, b);
        chk("unmapped", dbc_pkg::UNMAPPED_VALUE, b);
        // Small count so the IN run crosses zero
        model = 32'h2;
        wr_count(model);
        wr(dbc_pkg::CMD_OFFSET,
           dbc_pkg::BUS_TO_BUFFER_TRANSFER_CMD);
        for (int i = 0; i < 6; i++) begin
            for (t = 0; o_dma_wr_ready !== 1'b1 && t < 50; t++)
                @(posedge i_clk);
            timeout(t);
            @(posedge i_clk);
            i_dma_wr <= 1'b1;
            i_dma_wdata <= 8'($urandom);
            @(posedge i_clk);
            i_dma_wr <= 1'b0;
            in_q.push_back(i_dma_wdata);
            model = model - 32'h1;
            rd_count(v);
            chk("count_in", model, v);
        end
        repeat (3) @(posedge i_clk);
        chk("fifo_left", 32'h0, in_q.size());
        model = 32'h4;
        wr_count(model);
        wr(dbc_pkg::CMD_OFFSET,
           dbc_pkg::BUFFER_TO_BUS_TRANSFER_CMD);
        out_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (t = 0; takes <= i && t < 50; t++) @(posedge i_clk);
            timeout(t);
            @(posedge i_clk);
            i_dma_rd <= 1'b1;
            @(posedge i_clk);
            i_dma_rd <= 1'b0;
            #1 chk("dma_rd_valid", 32'h1, o_dma_rd_valid);
            chk("dma_rdata", 8'ha0 + 8'(i), o_dma_rdata);
            chk("buf_hold", 32'h1, o_buf_hold);
            model = model - 32'h1;
        end
        out_en <= 1'b0;
        rd_count(v);
        chk("count_out", model, v);
        // Low clock enable must swallow a count write
        i_clk_en <= 1'b0;
        wr(dbc_pkg::COUNT_OFFSET_B3, 8'h5a);
        i_clk_en <= 1'b1;
        rd_count(v);
        chk("count_frozen", model, v);
        wr(dbc_pkg::CMD_OFFSET, dbc_pkg::STOP_TRANSFER_CMD);
        @(posedge i_clk);
        #1 chk("busy_stop", 32'h0, o_busy);
        wr_count($urandom);
        @(posedge i_clk);
        i_usb_bus_reset <= 1'b1;
        @(posedge i_clk);
        i_usb_bus_reset <= 1'b0;
        rd_count(v);
        chk("count_bus_reset", dbc_pkg::COUNT_RESET, v);
        stop_test();
    end
endmodule
